/* verilog/wake_ctrl_pkg.sv */
// constants, field layout and carrier types of the wake and interrupt control block
package wake_ctrl_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_MODE        = 8'h04;
    localparam logic [7:0] OFS_STATUS      = 8'h08;
    localparam logic [7:0] OFS_CLEAR       = 8'h0c;
    localparam logic [7:0] OFS_ENABLE      = 8'h10;
    localparam logic [7:0] OFS_XCVR        = 8'h14;

    // field positions of the control register
    localparam int POS_UV_IRQ_EN   = 10;
    localparam int POS_LIN_STBY    = 9;
    localparam int POS_WAKE1_SEL   = 6;
    localparam int POS_WAKE2_SEL   = 4;
    localparam int POS_CAN_STBY    = 3;

    // bit positions of the status, clear and enable registers
    localparam int POS_EV_UV       = 10;
    localparam int POS_EV_LIN_WAKE = 9;
    localparam int POS_EV_WAKE1    = 6;
    localparam int POS_EV_WAKE2    = 4;
    localparam int POS_EV_CAN_WAKE = 3;
    localparam int EVENT_WIDTH     = 16;

    // field positions of the transceiver state register
    localparam int POS_XS_LIN      = 0;
    localparam int POS_XS_CAN      = 2;
    localparam int POS_XS_LIN_FLAG = 4;
    localparam int POS_XS_CAN_FLAG = 5;

    // values after reset
    localparam logic [1:0]  RST_MODE        = 2'h0;
    localparam logic [1:0]  RST_EDGE_SEL    = 2'h0;
    localparam logic [15:0] RST_ENABLE      = 16'h0000;

    // edge select encodings
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_FALL    = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // transceiver states
    typedef enum logic [1:0] {
        XCVR_OFF,
        XCVR_LOWPOWER,
        XCVR_ACTIVE
    } xcvr_state_t;

    // control register contents
    typedef struct packed {
        logic       can_supply_undervolt_irq_enable;
        logic       lin_standby_select;
        logic [1:0] wake_input_one_edge_select;
        logic [1:0] wake_input_two_edge_select;
        logic       can_standby_select;
    } ctrl_t;

    localparam ctrl_t RST_CTRL = '{1'b0, 1'b0, 2'h0, 2'h0, 1'b0};

endpackage

/* verilog/wake_edge_detect.sv */
// synchroniser and edge selectable event detector for a local wake input
`timescale 1ns/100ps
module wake_edge_detect (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // pin and selection
    input  wire logic       wake_pin,
    input  wire logic [1:0] edge_select,
    // detected event
    output logic            wake_event
);
    import wake_ctrl_pkg::*;

    logic sync_first;
    logic sync_second;
    logic last_level;

    // two stage synchroniser, first stage read only by second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            sync_first  <= wake_pin;
            sync_second <= sync_first;
        end
    end

    // previous synchronised level for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_level <= 1'b0;
        end else begin
            last_level <= sync_second;
        end
    end

    // one event per synchronised edge of the selected kind
    always_comb begin
        case (edge_select)
            EDGE_RISE: wake_event = sync_second & ~last_level;
            EDGE_FALL: wake_event = ~sync_second & last_level;
            EDGE_BOTH: wake_event = sync_second ^ last_level;
            default:   wake_event = 1'b0;
        endcase
    end

endmodule

/* verilog/sticky_flag_bank.sv */
// sticky event flags with write one to clear and an enable mask
`timescale 1ns/100ps
module sticky_flag_bank #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // events and software control
    input  wire logic [WIDTH-1:0] set_flags,
    input  wire logic [WIDTH-1:0] clear_flags,
    input  wire logic [WIDTH-1:0] enable_mask,
    // state
    output logic      [WIDTH-1:0] flags,
    output logic                  irq
);

    // a set in the same cycle as its clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clear_flags) | set_flags;
        end
    end

    // level interrupt while an enabled flag stands
    assign irq = |(flags & enable_mask);

endmodule

/* verilog/wake_interrupt_control_reg.sv */
// interrupt and wake control register bank with transceiver state control
//
// Operation
// - undervoltage interrupt enable at 0 blocks supply undervoltage interrupts
// - lin standby 0 in normal mode: lin active, wake flag cleared
// - lin standby 0 in standby or sleep: lin off, no wake detection
// - lin standby 1: lin lowpower with wake detection in every mode
// - wake input one edge select: none, rising, falling, both
// - wake input two edge select likewise, resetting to none
// - can standby 0 in normal mode: can active, wake flag cleared
// - writing one to a status bit clears that pending flag
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module wake_interrupt_control_reg (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // local wake pins
    input  wire logic                       wake_in_one,
    input  wire logic                       wake_in_two,
    // supply and bus monitor pins
    input  wire logic                       can_supply_undervolt,
    input  wire logic                       lin_bus_wake,
    input  wire logic                       can_bus_wake,
    input  wire logic                       lin_bus_data,
    input  wire logic                       can_bus_data,
    // transceiver control and receive outputs
    output wake_ctrl_pkg::xcvr_state_t      lin_state,
    output wake_ctrl_pkg::xcvr_state_t      can_state,
    output logic                            lin_receive_output,
    output logic                            can_receive_output,
    // interrupt
    output logic                            irq
);
    import wake_ctrl_pkg::*;

    // register contents
    ctrl_t                   ctrl;
    logic [1:0]              sbc_mode_field;
    logic [EVENT_WIDTH-1:0]  enable_mask;
    logic [EVENT_WIDTH-1:0]  status_flags;

    // bus phase decode
    logic                    setup_phase;
    logic                    write_strobe;
    logic                    addr_known;

    // synchronised pins
    logic [4:0]              pin_first;
    logic [4:0]              pin_second;
    logic                    uv_last;

    // events and clears
    logic [EVENT_WIDTH-1:0]  set_flags;
    logic [EVENT_WIDTH-1:0]  clear_flags;
    logic                    wake_one_event;
    logic                    wake_two_event;

    // transceiver state
    logic                    sbc_normal;
    logic                    lin_wake_flag;
    logic                    can_wake_flag;
    xcvr_state_t             next_lin_state;
    xcvr_state_t             next_can_state;

    // true when an address names one of the registers
    function automatic logic reg_mapped(input logic [7:0] addr);
        case (addr)
            OFS_CONTROL,
            OFS_MODE,
            OFS_STATUS,
            OFS_CLEAR,
            OFS_ENABLE,
            OFS_XCVR: reg_mapped = 1'b1;
            default:  reg_mapped = 1'b0;
        endcase
    endfunction

    // places the control fields at their register positions
    function automatic logic [31:0] pack_ctrl(input ctrl_t c);
        logic [31:0] word;
        word = 32'h0000_0000;
        word[POS_UV_IRQ_EN]          = c.can_supply_undervolt_irq_enable;
        word[POS_LIN_STBY]           = c.lin_standby_select;
        word[POS_WAKE1_SEL +: 2]     = c.wake_input_one_edge_select;
        word[POS_WAKE2_SEL +: 2]     = c.wake_input_two_edge_select;
        word[POS_CAN_STBY]           = c.can_standby_select;
        return word;
    endfunction


    // apb handshake
    // no wait states

    // read data is captured in setup, so access always completes at once
    assign setup_phase  = psel & ~penable;
    assign addr_known   = reg_mapped(paddr);
    assign write_strobe = psel & penable & pwrite & addr_known;

    // ready in every access cycle, error for unmapped addresses
    always_comb begin
        pready  = psel & penable;
        pslverr = psel & penable & ~addr_known;
    end

    // read data captured during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            case (paddr)
                OFS_CONTROL: prdata <= pack_ctrl(ctrl);
                OFS_MODE:    prdata <= {30'h0000_0000, sbc_mode_field};
                OFS_STATUS:  prdata <= {16'h0000, status_flags};
                OFS_ENABLE:  prdata <= {16'h0000, enable_mask};
                OFS_XCVR: begin
                    prdata                  <= 32'h0000_0000;
                    prdata[POS_XS_LIN +: 2] <= lin_state;
                    prdata[POS_XS_CAN +: 2] <= can_state;
                    prdata[POS_XS_LIN_FLAG] <= lin_wake_flag;
                    prdata[POS_XS_CAN_FLAG] <= can_wake_flag;
                end
                default:     prdata <= 32'h0000_0000; // clear register reads zero
            endcase
        end
    end


    // software written registers
    // host writable fields

    // control register fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= RST_CTRL; // edge selects start disabled
        end else if (write_strobe && paddr == OFS_CONTROL) begin
            ctrl.can_supply_undervolt_irq_enable <= pwdata[POS_UV_IRQ_EN];
            ctrl.lin_standby_select              <= pwdata[POS_LIN_STBY];
            ctrl.wake_input_one_edge_select      <= pwdata[POS_WAKE1_SEL +: 2];
            ctrl.wake_input_two_edge_select      <= pwdata[POS_WAKE2_SEL +: 2];
            ctrl.can_standby_select              <= pwdata[POS_CAN_STBY];
        end
    end

    // sbc operating mode, bit one high means normal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sbc_mode_field <= RST_MODE;
        end else if (write_strobe && paddr == OFS_MODE) begin
            sbc_mode_field <= pwdata[1:0];
        end
    end

    // interrupt enable mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_mask <= RST_ENABLE;
        end else if (write_strobe && paddr == OFS_ENABLE) begin
            enable_mask <= pwdata[EVENT_WIDTH-1:0];
        end
    end

    // write one to clear, through status or the clear alias
    always_comb begin
        clear_flags = '0;
        if (write_strobe && (paddr == OFS_STATUS || paddr == OFS_CLEAR)) begin
            clear_flags = pwdata[EVENT_WIDTH-1:0];
        end
    end


    // pin synchronisation
    // two flops per pin

    // two stages for supply and bus monitor pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_first  <= 5'h00;
            pin_second <= 5'h00;
        end else begin
            pin_first  <= {can_bus_data, lin_bus_data, can_bus_wake,
                           lin_bus_wake, can_supply_undervolt};
            pin_second <= pin_first;
        end
    end

    // previous undervoltage level for onset detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_last <= 1'b0;
        end else begin
            uv_last <= pin_second[0];
        end
    end


    // local wake inputs
    // one detector per pin

    // wake input one, synchronised then edge selected
    wake_edge_detect wake_one_detect (
        .pclk        (pclk),
        .presetn     (presetn),
        .wake_pin    (wake_in_one),
        .edge_select (ctrl.wake_input_one_edge_select),
        .wake_event  (wake_one_event)
    );

    // wake input two, synchronised then edge selected
    wake_edge_detect wake_two_detect (
        .pclk        (pclk),
        .presetn     (presetn),
        .wake_pin    (wake_in_two),
        .edge_select (ctrl.wake_input_two_edge_select),
        .wake_event  (wake_two_event)
    );


    // transceiver modes
    // from select and mode

    assign sbc_normal = sbc_mode_field[1];

    // lin mode from standby select and sbc mode
    always_comb begin
        if (ctrl.lin_standby_select) begin
            next_lin_state = XCVR_LOWPOWER;
        end else if (sbc_normal) begin
            next_lin_state = XCVR_ACTIVE;
        end else begin
            next_lin_state = XCVR_OFF;
        end
    end

    // can mode; standby select 1 handled as lowpower
    always_comb begin
        if (ctrl.can_standby_select) begin
            next_can_state = XCVR_LOWPOWER;
        end else if (sbc_normal) begin
            next_can_state = XCVR_ACTIVE;
        end else begin
            next_can_state = XCVR_OFF;
        end
    end

    // registered transceiver states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lin_state <= XCVR_OFF;
            can_state <= XCVR_OFF;
        end else begin
            lin_state <= next_lin_state;
            can_state <= next_can_state;
        end
    end

    // lin wake flag: set only while detection runs, cleared when active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lin_wake_flag <= 1'b0;
        end else begin
            case (lin_state)
                XCVR_ACTIVE:   lin_wake_flag <= 1'b0;
                XCVR_LOWPOWER: lin_wake_flag <= lin_wake_flag | pin_second[1];
                XCVR_OFF:      lin_wake_flag <= lin_wake_flag;
                default:       lin_wake_flag <= 1'b0;
            endcase
        end
    end

    // can wake flag: set in lowpower, cleared when active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_wake_flag <= 1'b0;
        end else begin
            case (can_state)
                XCVR_ACTIVE:   can_wake_flag <= 1'b0;
                XCVR_LOWPOWER: can_wake_flag <= can_wake_flag | pin_second[2];
                XCVR_OFF:      can_wake_flag <= can_wake_flag;
                default:       can_wake_flag <= 1'b0;
            endcase
        end
    end

    // receive outputs: bus data when active, else low while flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lin_receive_output <= 1'b1;
            can_receive_output <= 1'b1;
        end else begin
            lin_receive_output <= (lin_state == XCVR_ACTIVE) ? pin_second[3]
                                                             : ~lin_wake_flag;
            can_receive_output <= (can_state == XCVR_ACTIVE) ? pin_second[4]
                                                             : ~can_wake_flag;
        end
    end


    // interrupt events
    // edge events into flags

    // undervoltage gated by its enable in the control register, bus wakes by lowpower state, wake inputs ungated here
    always_comb begin
        set_flags                  = '0;
        set_flags[POS_EV_UV]       = ctrl.can_supply_undervolt_irq_enable
                                     & pin_second[0] & ~uv_last;
        set_flags[POS_EV_LIN_WAKE] = (lin_state == XCVR_LOWPOWER)
                                     & ctrl.lin_standby_select
                                     & pin_second[1] & ~lin_wake_flag;
        set_flags[POS_EV_WAKE1]    = wake_one_event;
        set_flags[POS_EV_WAKE2]    = wake_two_event;
        set_flags[POS_EV_CAN_WAKE] = (can_state == XCVR_LOWPOWER)
                                     & pin_second[2] & ~can_wake_flag;
    end

    // sticky status with enable mask onto one interrupt line
    sticky_flag_bank #(
        .WIDTH (EVENT_WIDTH)
    ) status_bank (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_flags   (set_flags),
        .clear_flags (clear_flags),
        .enable_mask (enable_mask),
        .flags       (status_flags),
        .irq         (irq)
    );

endmodule

/* verif/wake_ctrl_asserts.sv */
// concurrent checks of the wake control block ports
`timescale 1ns/100ps
module wake_ctrl_asserts (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // pins
    input wire logic                  wake_in_one,
    input wire logic                  wake_in_two,
    input wire logic                  can_supply_undervolt,
    input wire wake_ctrl_pkg::xcvr_state_t lin_state,
    input wire wake_ctrl_pkg::xcvr_state_t can_state,
    input wire logic                  irq
);
    import wake_ctrl_pkg::*;

    logic [10:0] sh_ctl;
    logic [1:0]  sh_mode;
    logic [15:0] sh_en;

    // shadows of control, mode and enable, taken at the write commit edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ctl <= '0;
            sh_mode <= '0;
            sh_en <= '0;
        end else if (psel && penable && pwrite) begin
            if (paddr == OFS_CONTROL) sh_ctl <= pwdata[10:0];
            if (paddr == OFS_MODE) sh_mode <= pwdata[1:0];
            if (paddr == OFS_ENABLE) sh_en <= pwdata[15:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lin_active: assert property (
        !sh_ctl[POS_LIN_STBY] && sh_mode[1] |=> lin_state == XCVR_ACTIVE)
        else $error("lin not active in normal mode");
    a_lin_off: assert property (
        !sh_ctl[POS_LIN_STBY] && !sh_mode[1] |=> lin_state == XCVR_OFF)
        else $error("lin not off in standby or sleep");
    a_lin_lowpower: assert property (
        sh_ctl[POS_LIN_STBY] |=> lin_state == XCVR_LOWPOWER)
        else $error("lin not lowpower with standby select");
    a_can_active: assert property (
        !sh_ctl[POS_CAN_STBY] && sh_mode[1] |=> can_state == XCVR_ACTIVE)
        else $error("can not active in normal mode");
    a_uv_masked: assert property (
        $rose(can_supply_undervolt) && !sh_ctl[POS_UV_IRQ_EN] && !irq |-> !irq[*5])
        else $error("undervoltage interrupt while disabled");
    a_wake_one_rise: assert property (
        $rose(wake_in_one) && sh_ctl[7:6] == EDGE_RISE && sh_en[6] |-> ##3 irq)
        else $error("wake one rising edge missed");
    a_wake_one_quiet: assert property (
        $rose(wake_in_one) && sh_ctl[7:6] == EDGE_FALL && !irq |-> !irq[*5])
        else $error("wake one fired on wrong edge");
    a_wake_two_fall: assert property (
        $fell(wake_in_two) && sh_ctl[5] && sh_en[4] |-> ##3 irq)
        else $error("wake two falling edge missed");
    a_clear_all: assert property (
        psel && penable && pwrite && paddr == OFS_CLEAR && pwdata[15:0] == 16'hffff
        |=> !irq)
        else $error("interrupt survived clear");
    a_bus_answer: assert property (
        psel && penable |-> pready && (pslverr == (paddr > OFS_XCVR || paddr[1:0] != 2'h0)))
        else $error("bad apb answer");
    a_unmapped_zero: assert property (
        psel && penable && !pwrite && paddr > OFS_XCVR |-> prdata == 32'h0)
        else $error("unmapped read not zero");

    c_irq: cover property ($rose(irq));
    c_lowpower: cover property (lin_state == XCVR_LOWPOWER);
    c_slverr: cover property (pslverr);
endmodule

bind wake_interrupt_control_reg wake_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_in_one, .wake_in_two,
    .can_supply_undervolt, .lin_state, .can_state, .irq);

/* verif/apb_host.sv */
// host model: apb master issuing single register transfers
`timescale 1ns/100ps
module apb_host (
    // clock
    input  wire logic        pclk,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // setup, then access held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            ok = pready;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

/* verif/tb.sv */
// self checking bench for the wake and interrupt control block
`timescale 1ns/100ps
module tb;
    import wake_ctrl_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic        wake_in_one, wake_in_two, can_supply_undervolt, lin_bus_wake;
    logic        can_bus_wake, lin_bus_data, can_bus_data;
    logic        lin_receive_output, can_receive_output;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    xcvr_state_t lin_state, can_state;
    int          n_mismatch, compares;
    bit          ok;

    wake_interrupt_control_reg DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .wake_in_one, .wake_in_two,
        .can_supply_undervolt, .lin_bus_wake, .can_bus_wake, .lin_bus_data, .can_bus_data,
        .lin_state, .can_state, .lin_receive_output, .can_receive_output, .irq);
    apb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);

    // clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task summarize;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected at %0t got %h expected %h", $time, g, x);
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        host.xfer(w, a, d, rdat, rerr, ok);
        if (!ok) begin
            n_mismatch++;
            summarize();
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(rdat, x);
    endtask

    // drive one pin after an edge, then let it settle
    task pin(input int k, input logic v);
        @(posedge pclk);
        case (k)
            0: wake_in_one <= v;
            1: wake_in_two <= v;
            2: can_supply_undervolt <= v;
            3: lin_bus_wake <= v;
            4: can_bus_wake <= v;
            5: lin_bus_data <= v;
            default: can_bus_data <= v;
        endcase
        repeat (5) @(posedge pclk);
    endtask

    task t_reset;
        rd(OFS_CONTROL, 32'h0); // edge fields clear
        rd(OFS_MODE, 32'h0);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_ENABLE, 32'h0);
        rd(OFS_XCVR, 32'h0);
        chk(32'(lin_receive_output), 32'h1);
        $display("t_reset done");
    endtask

    task t_modes;
        int i;
        logic [1:0] el, ec;
        for (i = 0; i < 16; i++) begin
            wr(OFS_CONTROL, (32'(i[3]) << POS_LIN_STBY) | (32'(i[2]) << POS_CAN_STBY));
            wr(OFS_MODE, 32'(i[1:0]));
            repeat (2) @(negedge pclk);
            el = i[3] ? XCVR_LOWPOWER : (i[1] ? XCVR_ACTIVE : XCVR_OFF);
            ec = i[2] ? XCVR_LOWPOWER : (i[1] ? XCVR_ACTIVE : XCVR_OFF);
            chk(32'(lin_state), 32'(el)); // lin state
            chk(32'(can_state), 32'(ec)); // can state
        end
        rd(OFS_CONTROL, 32'h0208);
        $display("t_modes done");
    endtask

    task t_uv;
        wr(OFS_ENABLE, 32'h0658);
        wr(OFS_CONTROL, 32'h0);
        pin(2, 1'b1);
        pin(2, 1'b0);
        rd(OFS_STATUS, 32'h0); // disabled source
        wr(OFS_CONTROL, 32'h1 << POS_UV_IRQ_EN);
        pin(2, 1'b1);
        pin(2, 1'b0);
        rd(OFS_STATUS, 32'h0400); // enabled source
        @(negedge pclk);
        chk(32'(irq), 32'h1);
        wr(OFS_ENABLE, 32'h0);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        wr(OFS_ENABLE, 32'h0658);
        wr(OFS_STATUS, 32'h0400); // write one clears
        rd(OFS_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        $display("t_uv done");
    endtask

    task t_wake(input int j);
        int s, pos, fs;
        pos = j ? POS_EV_WAKE2 : POS_EV_WAKE1;
        fs = j ? POS_WAKE2_SEL : POS_WAKE1_SEL;
        for (s = 0; s < 4; s++) begin
            wr(OFS_CONTROL, 32'(s) << fs);
            pin(j, 1'b1);
            rd(OFS_STATUS, 32'(s[0]) << pos); // rising decode
            @(negedge pclk);
            chk(32'(irq), 32'(s[0]));
            wr(OFS_CLEAR, 32'hffff); // clear pending
            repeat (4) @(posedge pclk);
            rd(OFS_STATUS, 32'h0); // single event
            pin(j, 1'b0);
            rd(OFS_STATUS, 32'(s[1]) << pos); // falling decode
            wr(OFS_CLEAR, 32'hffff);
        end
        $display("t_wake done");
    endtask

    task t_xcvr;
        wr(OFS_CONTROL, 32'h1 << POS_LIN_STBY);
        wr(OFS_MODE, 32'h0);
        pin(3, 1'b1);
        pin(3, 1'b0);
        rd(OFS_STATUS, 32'h1 << POS_EV_LIN_WAKE); // lowpower wake
        chk(32'(lin_receive_output), 32'h0);
        wr(OFS_CLEAR, 32'hffff);
        wr(OFS_CONTROL, 32'h1 << POS_CAN_STBY);
        pin(3, 1'b1);
        pin(3, 1'b0);
        pin(4, 1'b1);
        pin(4, 1'b0);
        rd(OFS_STATUS, 32'h1 << POS_EV_CAN_WAKE); // no lin wake when off
        chk(32'(can_receive_output), 32'h0);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_MODE, 32'h2);
        pin(5, 1'b0);
        pin(6, 1'b0);
        rd(OFS_XCVR, 32'h0a); // flags cleared
        chk(32'(lin_receive_output), 32'h0);
        pin(5, 1'b1);
        pin(6, 1'b1);
        chk(32'(lin_receive_output), 32'h1); // follows bus
        chk(32'(can_receive_output), 32'h1); // follows bus
        wr(OFS_XCVR, 32'h0);
        rd(OFS_XCVR, 32'h0a);
        wr(OFS_CLEAR, 32'hffff);
        $display("t_xcvr done");
    endtask

    task t_bus;
        bus(1'b0, 8'h40, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(rdat, 32'h0);
        bus(1'b1, 8'h44, 32'hffff);
        chk(32'(rerr), 32'h1);
        rd(OFS_CLEAR, 32'h0);
        $display("t_bus done");
    endtask

    // main sequence
    initial begin
        n_mismatch = 0;
        compares = 0;
        presetn = 1'b0;
        {wake_in_one, wake_in_two, can_supply_undervolt, lin_bus_wake, can_bus_wake} = 5'h00;
        {lin_bus_data, can_bus_data} = 2'h3;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_uv();
        t_wake(0);
        t_wake(1);
        t_xcvr();
        t_bus();
        summarize();
    end
endmodule
